/* core/cbd_pkg.sv */
package cbd_pkg;

	// ==========================================================
	// Instruction fields
	// ==========================================================
	localparam int unsigned CBD_XLEN = 32;
	localparam logic [15:0] CBD_COND_CLASS = 16'hd000; // 1101 xxxx
	localparam logic [15:0] CBD_COND_MASK = 16'hf000;
	localparam logic [15:0] CBD_UNCOND_CLASS = 16'he000; // 11100 x
	localparam logic [15:0] CBD_LONG_CLASS = 16'hf000; // 1111 H x
	localparam logic [15:0] CBD_FIVE_MASK = 16'hf800;
	localparam logic [15:0] CBD_LONG_MASK = 16'hf000;
	localparam int unsigned CBD_COND_LSB = 8;
	localparam int unsigned CBD_LONG_H_BIT = 11;

	// ==========================================================
	// Condition codes
	// ==========================================================
	localparam logic [3:0] CBD_CC_EQ = 4'h0;
	localparam logic [3:0] CBD_CC_NE = 4'h1;
	localparam logic [3:0] CBD_CC_CS = 4'h2;
	localparam logic [3:0] CBD_CC_CC = 4'h3;
	localparam logic [3:0] CBD_CC_MI = 4'h4;
	localparam logic [3:0] CBD_CC_PL = 4'h5;
	localparam logic [3:0] CBD_CC_VS = 4'h6;
	localparam logic [3:0] CBD_CC_VC = 4'h7;
	localparam logic [3:0] CBD_CC_HI = 4'h8;
	localparam logic [3:0] CBD_CC_LS = 4'h9;
	localparam logic [3:0] CBD_CC_GE = 4'ha;
	localparam logic [3:0] CBD_CC_LT = 4'hb;
	localparam logic [3:0] CBD_CC_GT = 4'hc;
	localparam logic [3:0] CBD_CC_LE = 4'hd;
	localparam logic [3:0] CBD_CC_UNDEF = 4'he;
	localparam logic [3:0] CBD_CC_TRAP = 4'hf;

	// ==========================================================
	// Status word, vectors, prefetch
	// ==========================================================
	localparam int unsigned CBD_FLAG_N = 31;
	localparam int unsigned CBD_FLAG_Z = 30;
	localparam int unsigned CBD_FLAG_C = 29;
	localparam int unsigned CBD_FLAG_V = 28;
	localparam int unsigned CBD_STATE_BIT = 5; // 1 = compact state
	localparam logic [4:0] CBD_MODE_SUPERVISOR = 5'h13;
	localparam logic [CBD_XLEN-1:0] CBD_TRAP_VECTOR = 32'h0000_0008;
	localparam logic [CBD_XLEN-1:0] CBD_PREFETCH = 32'h0000_0004;
	localparam logic [CBD_XLEN-1:0] CBD_HALF = 32'h0000_0002;
	localparam logic [CBD_XLEN-1:0] CBD_RESET_PC = 32'h0000_0000;
	localparam logic [CBD_XLEN-1:0] CBD_RESET_WORD = 32'h0000_0000;
	localparam int unsigned CBD_LONG_SHIFT = 12;
	localparam int unsigned CBD_SHORT_MSB = 7; // Top bit of the short offset field
	localparam int unsigned CBD_LONG_MSB = 10; // Top bit of the eleven-bit offset field
	localparam int unsigned CBD_MODE_MSB = 4; // Top bit of the mode field
	localparam logic [CBD_XLEN-1:0] CBD_LINK_MARK = 32'h0000_0001; // Bit 0 set in a call's return link

	// Pending kind of the current decode
	typedef enum logic [4:0] {
		CBD_K_NONE = 5'b00001,
		CBD_K_BRANCH = 5'b00010,
		CBD_K_TRAP = 5'b00100,
		CBD_K_LINK_HI = 5'b01000,
		CBD_K_UNDEF = 5'b10000
	} cbd_kind_e;

endpackage : cbd_pkg

/* core/cbd_compact_branch_decoder.sv */
// Operation
// - Conditional branch only when flag test passes
// - Targets use PC four bytes ahead
// - 0000 Z set, 0001 Z clear
// - 0010 C set, 0011 C clear
// - 0100 N set, 0101 N clear
// - 0110 V set, 0111 V clear
// - 1000 C set and Z clear
// - 1001 C clear or Z set
// - 1010 N equals V
// - 1011 N differs from V
// - 1100 Z clear and N equals V
// - 1101 Z set or N differs V
// - Short offset doubled, sign-extended nine bits
// - 1110 undefined; 1111 is software trap
// - Trap saves link, status; vector, supervisor
// - Trap comment byte is ignored
// - Unconditional branch, eleven-bit doubled offset
// - First half: PC plus offset<<12 into link
// - Second half: jump, link next address|1
// - Cycle counts match wide equivalents
`timescale 1ns/1ps
`default_nettype none

module cbd_compact_branch_decoder
	import cbd_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic nrst_in,
	// Issued instruction
	input wire logic issue_valid_in,
	input wire logic [15:0] issue_instr_in,
	input wire logic [CBD_XLEN-1:0] issue_addr_in,
	// Processor state
	input wire logic [CBD_XLEN-1:0] current_status_word_in,
	input wire logic [CBD_XLEN-1:0] link_register_in,
	// Fetch redirect
	output logic flush_out,
	output logic [CBD_XLEN-1:0] target_out,
	// Link register write
	output logic link_we_out,
	output logic [CBD_XLEN-1:0] link_register_out,
	// Status updates for trap
	output logic trap_out,
	output logic [CBD_XLEN-1:0] saved_status_word_out,
	output logic [CBD_XLEN-1:0] new_status_word_out,
	// Undefined-instruction exception
	output logic undef_out
);

	// ==========================================================
	// Decode
	// ==========================================================
	logic is_cond; // Conditional branch format
	logic is_uncond; // Unconditional branch
	logic is_long; // Long call pair half
	logic long_hi; // H = 0 half
	logic [3:0] cond; // Condition field
	logic flag_n, flag_z, flag_c, flag_v; // Status flags
	logic cond_pass; // Condition satisfied
	logic [CBD_XLEN-1:0] pc_ahead; // Prefetch-adjusted PC
	logic [CBD_XLEN-1:0] next_addr; // Following instruction
	logic [CBD_XLEN-1:0] short_off; // Short branch offset
	logic [CBD_XLEN-1:0] uncond_off; // Unconditional offset
	logic [CBD_XLEN-1:0] long_off_hi; // Upper long offset
	logic [CBD_XLEN-1:0] long_off_lo; // Lower long offset
	cbd_kind_e kind; // Decoded action
	logic [CBD_XLEN-1:0] tgt_d, link_d, status_d;

	assign is_cond = (issue_instr_in & CBD_COND_MASK) == CBD_COND_CLASS;
	assign is_uncond = (issue_instr_in & CBD_FIVE_MASK) == CBD_UNCOND_CLASS;
	assign is_long = (issue_instr_in & CBD_LONG_MASK) == CBD_LONG_CLASS;
	assign long_hi = ~issue_instr_in[CBD_LONG_H_BIT];
	assign cond = issue_instr_in[CBD_COND_LSB +: 4];
	assign flag_n = current_status_word_in[CBD_FLAG_N];
	assign flag_z = current_status_word_in[CBD_FLAG_Z];
	assign flag_c = current_status_word_in[CBD_FLAG_C];
	assign flag_v = current_status_word_in[CBD_FLAG_V];

	// PC is one word ahead of the executing instruction
	assign pc_ahead = issue_addr_in + CBD_PREFETCH;
	assign next_addr = issue_addr_in + CBD_HALF;

	// Offset extensions; the signed size cast does the sign fill
	assign short_off = CBD_XLEN'($signed({issue_instr_in[CBD_SHORT_MSB:0], 1'b0}));
	assign uncond_off = CBD_XLEN'($signed({issue_instr_in[CBD_LONG_MSB:0], 1'b0}));
	assign long_off_hi = CBD_XLEN'($signed({issue_instr_in[CBD_LONG_MSB:0], {CBD_LONG_SHIFT{1'b0}}}));
	// Lower half adds unsigned, the upper half already carries the sign
	assign long_off_lo = CBD_XLEN'({issue_instr_in[CBD_LONG_MSB:0], 1'b0});

	// Flag test per condition code
	always_comb begin
		case (cond)
			CBD_CC_EQ: cond_pass = flag_z;
			CBD_CC_NE: cond_pass = ~flag_z;
			CBD_CC_CS: cond_pass = flag_c;
			CBD_CC_CC: cond_pass = ~flag_c;
			CBD_CC_MI: cond_pass = flag_n;
			CBD_CC_PL: cond_pass = ~flag_n;
			CBD_CC_VS: cond_pass = flag_v;
			CBD_CC_VC: cond_pass = ~flag_v;
			CBD_CC_HI: cond_pass = flag_c & ~flag_z;
			CBD_CC_LS: cond_pass = ~flag_c | flag_z;
			CBD_CC_GE: cond_pass = flag_n == flag_v;
			CBD_CC_LT: cond_pass = flag_n != flag_v;
			CBD_CC_GT: cond_pass = ~flag_z & (flag_n == flag_v);
			CBD_CC_LE: cond_pass = flag_z | (flag_n != flag_v);
			default: cond_pass = 1'b0;
		endcase
	end

	// Action select and result values
	always_comb begin
		kind = CBD_K_NONE;
		tgt_d = pc_ahead + short_off;
		link_d = link_register_in;
		status_d = current_status_word_in;
		if (issue_valid_in) begin
			if (is_cond) begin
				if (cond == CBD_CC_TRAP) begin
					// Comment byte plays no part in the trap
					kind = CBD_K_TRAP;
					tgt_d = CBD_TRAP_VECTOR;
					link_d = next_addr;
					status_d[CBD_STATE_BIT] = 1'b0;
					status_d[CBD_MODE_MSB:0] = CBD_MODE_SUPERVISOR;
				end else if (cond == CBD_CC_UNDEF) begin
					kind = CBD_K_UNDEF;
				end else if (cond_pass) begin
					kind = CBD_K_BRANCH;
				end
			end else if (is_uncond) begin
				kind = CBD_K_BRANCH;
				tgt_d = pc_ahead + uncond_off;
			end else if (is_long) begin
				if (long_hi) begin
					kind = CBD_K_LINK_HI;
					link_d = pc_ahead + long_off_hi;
				end else begin
					kind = CBD_K_BRANCH;
					tgt_d = link_register_in + long_off_lo;
					link_d = next_addr | CBD_LINK_MARK;
				end
			end
		end
	end

	// ==========================================================
	// Registered outputs, one cycle after issue
	// ==========================================================
	// Fetch redirect; single-cycle result matches wide branch timing
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			flush_out <= 1'b0;
			target_out <= CBD_RESET_PC;
		end else begin
			flush_out <= (kind == CBD_K_BRANCH) || (kind == CBD_K_TRAP);
			target_out <= tgt_d;
		end
	end

	// Link register writes
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			link_we_out <= 1'b0;
			link_register_out <= CBD_RESET_WORD;
		end else begin
			link_we_out <= (kind == CBD_K_TRAP) || (kind == CBD_K_LINK_HI)
				|| (kind == CBD_K_BRANCH && is_long);
			link_register_out <= link_d;
		end
	end

	// Trap status save and mode switch
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			trap_out <= 1'b0;
			saved_status_word_out <= CBD_RESET_WORD;
			new_status_word_out <= CBD_RESET_WORD;
		end else begin
			trap_out <= kind == CBD_K_TRAP;
			saved_status_word_out <= current_status_word_in;
			new_status_word_out <= status_d;
		end
	end

	// Undefined-instruction exception
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			undef_out <= 1'b0;
		end else begin
			undef_out <= kind == CBD_K_UNDEF;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	logic [15:0] instr_q; // Helper copy of previous instruction
	logic vld_q; // Helper copy of previous valid
	logic [CBD_XLEN-1:0] addr_q, lr_q; // Helper copies
	logic rst_q; // Reset applied at the previous edge
	always_ff @(posedge mclk_in) begin
		instr_q <= issue_instr_in;
		vld_q <= issue_valid_in && nrst_in; // No answer follows a reset cycle
		rst_q <= !nrst_in;
		addr_q <= issue_addr_in;
		lr_q <= link_register_in;
	end

	eq_taken_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd0 && current_status_word_in[CBD_FLAG_Z]
		|=> flush_out && target_out == $past(issue_addr_in) + 32'h4 + {{23{instr_q[7]}}, instr_q[7:0], 1'b0})
		else $error("equal branch not taken correctly");
	ne_fall_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd1 && current_status_word_in[CBD_FLAG_Z]
		|=> !flush_out)
		else $error("not-equal branch taken with Z set");
	gt_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hdc
		|=> flush_out == (!$past(flag_z) && $past(flag_n) == $past(flag_v)))
		else $error("greater-than test wrong");
	hi_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd8
		|=> flush_out == ($past(flag_c) && !$past(flag_z)))
		else $error("unsigned higher test wrong");
	trap_entry_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		trap_out |-> flush_out && target_out == 32'h8 && link_register_out == addr_q + 32'h2
		&& new_status_word_out[4:0] == 5'h13 && !new_status_word_out[5])
		else $error("trap entry wrong");
	undef_op_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hde |=> undef_out && !flush_out)
		else $error("undefined condition not trapped");
	uncond_tgt_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		vld_q && instr_q[15:11] == 5'h1c |-> flush_out
		&& target_out == addr_q + 32'h4 + {{20{instr_q[10]}}, instr_q[10:0], 1'b0})
		else $error("unconditional target wrong");
	long_hi_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		vld_q && instr_q[15:11] == 5'h1e |-> link_we_out && !flush_out
		&& link_register_out == addr_q + 32'h4 + {{9{instr_q[10]}}, instr_q[10:0], 12'h000})
		else $error("long call first half wrong");
	long_lo_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		vld_q && instr_q[15:11] == 5'h1f |-> flush_out && link_register_out == ((addr_q + 32'h2) | 32'h1)
		&& target_out == lr_q + {20'h00000, instr_q[10:0], 1'b0})
		else $error("long call second half wrong");

	// ==========================================================
	// Condition code, trap save and quiet-output assertions
	// ==========================================================
	cs_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd2
		|=> flush_out == $past(flag_c))
		else $error("carry-set test wrong");
	cc_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd3
		|=> flush_out == !$past(flag_c))
		else $error("carry-clear test wrong");
	mi_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd4
		|=> flush_out == $past(flag_n))
		else $error("negative test wrong");
	pl_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd5
		|=> flush_out == !$past(flag_n))
		else $error("positive test wrong");
	vs_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd6
		|=> flush_out == $past(flag_v))
		else $error("overflow-set test wrong");
	vc_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd7
		|=> flush_out == !$past(flag_v))
		else $error("overflow-clear test wrong");
	ls_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hd9
		|=> flush_out == (!$past(flag_c) || $past(flag_z)))
		else $error("unsigned lower-or-same test wrong");
	ge_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hda
		|=> flush_out == ($past(flag_n) == $past(flag_v)))
		else $error("signed greater-or-equal test wrong");
	lt_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hdb
		|=> flush_out == ($past(flag_n) != $past(flag_v)))
		else $error("signed less-than test wrong");
	le_cond_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		issue_valid_in && issue_instr_in[15:8] == 8'hdd
		|=> flush_out == ($past(flag_z) || ($past(flag_n) != $past(flag_v))))
		else $error("signed less-or-equal test wrong");
	trap_save_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		vld_q && instr_q[15:8] == 8'hdf |-> trap_out && link_we_out
		&& saved_status_word_out == $past(current_status_word_in))
		else $error("trap with any comment byte not taken");
	idle_quiet_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		!vld_q |-> !flush_out && !link_we_out && !trap_out && !undef_out)
		else $error("strobe without an issued instruction");
	rst_quiet_a: assert property (@(posedge mclk_in)
		rst_q |-> !flush_out && !link_we_out && !trap_out && !undef_out)
		else $error("strobe raised during reset");

endmodule : cbd_compact_branch_decoder // cbd_compact_branch_decoder

`default_nettype wire

/* test/cbd_reg_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Link register state beside the decoder
// ==========================================================
module cbd_reg_model
	import cbd_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic nrst_in,
	// Link write from decoder
	input wire logic link_we_in,
	input wire logic [CBD_XLEN-1:0] link_wdata_in,
	// Link value seen by decoder
	output logic [CBD_XLEN-1:0] link_rdata_out
);
	logic [CBD_XLEN-1:0] lr_q; // Stored link register

	// Store each link write
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			lr_q <= CBD_RESET_WORD;
		end else if (link_we_in) begin
			lr_q <= link_wdata_in;
		end
	end

	// Forward a write in flight so a second half sees the first half's sum
	assign link_rdata_out = link_we_in ? link_wdata_in : lr_q;
endmodule // cbd_reg_model

`default_nettype wire

/* test/compact_branch_decoder_bench.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench top
// ==========================================================
module compact_branch_decoder_bench;
	import cbd_pkg::*;
	logic mclk_in = 1'b0; // Core clock
	logic nrst_in = 1'b0; // Reset, active low
	logic issue_valid_in = 1'b0; // Instruction present
	logic [15:0] issue_instr_in = 16'h0000; // Instruction
	logic [31:0] issue_addr_in = 32'h0; // Its address
	logic [31:0] current_status_word_in = 32'h0; // Status word
	wire logic [31:0] link_rd, target_out, link_register_out, sav_o, new_o; // Data outputs
	wire logic flush_out, link_we_out, trap_out, undef_out; // Strobes
	logic [31:0] exp_lr = 32'h0; // Link value the bench expects
	logic [31:0] rng = 32'h1; // Xorshift state
	int n_fail = 0;
	int n_compared = 0;

	// Clock, 8 ns period
	always #4 mclk_in = ~mclk_in;

	cbd_compact_branch_decoder dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .issue_valid_in(issue_valid_in),
		.issue_instr_in(issue_instr_in), .issue_addr_in(issue_addr_in),
		.current_status_word_in(current_status_word_in), .link_register_in(link_rd), .flush_out(flush_out),
		.target_out(target_out), .link_we_out(link_we_out), .link_register_out(link_register_out),
		.trap_out(trap_out), .saved_status_word_out(sav_o), .new_status_word_out(new_o), .undef_out(undef_out));
	cbd_reg_model reg_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .link_we_in(link_we_out),
		.link_wdata_in(link_register_out), .link_rdata_out(link_rd));

	// Next pseudo-random word
	function logic [31:0] nxt();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// Flag test of one condition code
	function automatic logic cond_ok(input logic [3:0] cc, input logic [31:0] s);
		logic n, z, c, v;
		n = s[CBD_FLAG_N];
		z = s[CBD_FLAG_Z];
		c = s[CBD_FLAG_C];
		v = s[CBD_FLAG_V];
		case (cc)
			CBD_CC_EQ: return z;
			CBD_CC_NE: return !z;
			CBD_CC_CS: return c;
			CBD_CC_CC: return !c;
			CBD_CC_MI: return n;
			CBD_CC_PL: return !n;
			CBD_CC_VS: return v;
			CBD_CC_VC: return !v;
			CBD_CC_HI: return c && !z;
			CBD_CC_LS: return !c || z;
			CBD_CC_GE: return n == v;
			CBD_CC_LT: return n != v;
			CBD_CC_GT: return !z && (n == v);
			CBD_CC_LE: return z || (n != v);
			default: return 1'b0;
		endcase
	endfunction

	// Compare one value
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Issue one instruction and check the answer one cycle later
	task automatic issue(input logic v, input logic [15:0] i, input logic [31:0] a, input logic [31:0] s);
		logic fl, tr, lw, ud;
		logic [31:0] tg, lk, ns;
		fl = 1'b0;
		tr = 1'b0;
		lw = 1'b0;
		ud = 1'b0;
		tg = 32'h0;
		lk = 32'h0;
		ns = {s[31:6], 1'b0, CBD_MODE_SUPERVISOR};
		if (v && i[15:12] == 4'hd) begin
			if (i[11:8] == CBD_CC_UNDEF) begin
				ud = 1'b1;
			end else if (i[11:8] == CBD_CC_TRAP) begin
				{tr, fl, lw, tg, lk} = {3'b111, CBD_TRAP_VECTOR, a + 32'h2};
			end else begin
				fl = cond_ok(i[11:8], s);
				tg = a + 32'h4 + {{23{i[7]}}, i[7:0], 1'b0};
			end
		end else if (v && i[15:11] == 5'h1c) begin
			{fl, tg} = {1'b1, a + 32'h4 + {{20{i[10]}}, i[10:0], 1'b0}};
		end else if (v && i[15:12] == 4'hf && !i[11]) begin
			{lw, lk} = {1'b1, a + 32'h4 + {{9{i[10]}}, i[10:0], 12'h0}};
		end else if (v && i[15:12] == 4'hf) begin
			{fl, tg, lw, lk} = {1'b1, exp_lr + {20'h0, i[10:0], 1'b0}, 1'b1, (a + 32'h2) | 32'h1};
		end
		@(negedge mclk_in);
		{issue_valid_in, issue_instr_in, issue_addr_in, current_status_word_in} = {v, i, a, s};
		@(posedge mclk_in);
		#1;
		check(flush_out, fl);
		check(undef_out, ud);
		check(trap_out, tr);
		check(link_we_out, lw);
		if (fl) check(target_out, tg);
		if (lw) check(link_register_out, lk);
		if (tr) check(sav_o, s);
		if (tr) check(new_o, ns);
		if (lw) exp_lr = lk;
	endtask

	// Verdict and end of run
	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Cut a hang short
	initial begin
		#400000;
		n_fail++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		logic [7:0] so8 [3]; // Short offset corners
		logic [10:0] hi11 [3]; // Eleven-bit corners, upper halves
		logic [10:0] lo11 [3]; // Eleven-bit corners, lower halves
		so8 = '{8'h80, 8'h7f, 8'h00};
		hi11 = '{11'h400, 11'h3ff, 11'h7ff};
		lo11 = '{11'h7ff, 11'h000, 11'h3ff};
		repeat (3) @(posedge mclk_in);
		@(negedge mclk_in);
		nrst_in = 1'b1;
		for (int k = 0; k < 256; k++) begin
			issue(1'b1, {4'hd, k[7:4], 8'(nxt() >> 24)}, nxt() & 32'hffff_fffe, {k[3:0], 28'(nxt() >> 4)});
		end
		$display("Condition table done");
		for (int j = 0; j < 3; j++) begin
			issue(1'b1, {8'hd0, so8[j]}, 32'h0000_1000, 32'h4000_0000);
		end
		for (int j = 0; j < 3; j++) begin
			issue(1'b1, {5'h1c, hi11[j]}, 32'h0000_2000, nxt());
			issue(1'b1, {5'h1e, hi11[j]}, 32'h0000_3000, nxt());
			issue(1'b1, {5'h1f, lo11[j]}, 32'h0000_3002, nxt());
		end
		issue(1'b0, 16'hd0fe, 32'h0, 32'h4000_0000);
		$display("Corner offsets done");
		// Mid-run reset with a trap on the pins: every strobe stays low
		@(negedge mclk_in);
		{nrst_in, issue_valid_in, issue_instr_in} = {1'b0, 1'b1, 16'hdf00};
		@(posedge mclk_in);
		#1;
		check({flush_out, trap_out, link_we_out, undef_out}, 4'h0);
		check(link_register_out, CBD_RESET_WORD);
		@(negedge mclk_in);
		{nrst_in, issue_valid_in} = 2'b10;
		@(posedge mclk_in);
		#1;
		check({flush_out, trap_out, link_we_out, undef_out}, 4'h0);
		exp_lr = CBD_RESET_WORD;
		$display("Reset corner done");
		for (int k = 0; k < 400; k++) begin
			issue(nxt() % 8 != 0, 16'(nxt() >> 16), nxt() & 32'hffff_fffe, nxt());
		end
		issue(1'b0, 16'h0000, 32'h0, 32'h0);
		$display("Random mix done");
		tally_and_finish();
	end
endmodule // compact_branch_decoder_bench

`default_nettype wire
